//--- rtl/prom_ctrl_pkg.sv
// Package for the byte-wide programmable memory controller.
// Assumes one 10 MHz system clock; all timing counts derive from it.
package prom_ctrl_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int DEPTH = 524288;
  localparam int CLK_HZ = 10_000_000;
  // Program pulse width in microseconds, a plain default.
  localparam int PULSE_US = 100;
  localparam int PULSE_CYC = (PULSE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    PULSE_US * (CLK_HZ / 1_000_000);
  // Access time to wait before sampling read data, in ns, rounded up.
  localparam int ACCESS_NS = 150;
  localparam int ACCESS_CYC = (ACCESS_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Setup time around supply and enable changes, in ns.
  localparam int SETUP_NS = 2000;
  localparam int SETUP_CYC = (SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MAX_TRIES = 10;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  // Address bit used to enter identification mode and its select bit.
  localparam int ID_BIT = 9;
  localparam int ID_SEL_BIT = 0;
  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ID} op_t;
endpackage

//--- rtl/prom_ctrl.sv
// Host-side controller that drives the memory pins for read, program, and identification.
// Assumes a single memory on the data lines and external drivers for program and id voltages.
//
// Operation
// - The host keeps a memory deselected by holding chip select or output enable high.
// - Programming starts with program supply high, both enables high, address and data set.
// - With stable address and data, chip select pulses low for the pulse width, output enable high.
// - Every location gets one pulse in a first pass before the verify phase.
// - The verify phase reads back and repulses on mismatch, at most 10 times per location.
// - In id mode the lowest address bit picks the byte and other address lines are held low.
`timescale 1ns/1ns
module prom_ctrl #(
  parameter int PULSE_CYC = prom_ctrl_pkg::PULSE_CYC,
  parameter int FIRST = 0,
  parameter int LAST = prom_ctrl_pkg::DEPTH - 1
) (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // User request port.
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [1:0] REQ_OP,
  input wire logic [prom_ctrl_pkg::ADDR_W-1:0] REQ_ADDR,
  output logic [prom_ctrl_pkg::ADDR_W-1:0] PROG_ADDR,
  input wire logic [prom_ctrl_pkg::DATA_W-1:0] PROG_DATA,
  output logic DONE,
  output logic FAIL,
  output logic [prom_ctrl_pkg::DATA_W-1:0] RD_DATA,
  // Memory pins.
  output logic [prom_ctrl_pkg::ADDR_W-1:0] ADDRESS_LINES,
  input wire logic [prom_ctrl_pkg::DATA_W-1:0] DATA_LINES_IN,
  output logic [prom_ctrl_pkg::DATA_W-1:0] DATA_LINES_OUT,
  output logic DATA_LINES_OE,
  output logic CHIP_SEL_B,
  output logic OUT_EN_B,
  output logic PROG_SUPPLY_EN,
  output logic ID_HV_EN
);
  typedef enum logic [3:0] {IDLE, SETUP, RD_WAIT, P1_SET, P1_PULSE, P1_HOLD,
    V_SET, V_READ, V_PULSE, V_HOLD, FINISH} state_t;
  localparam int CW = 16;
  localparam logic [CW-1:0] ACC = CW'(prom_ctrl_pkg::ACCESS_CYC);
  localparam logic [CW-1:0] SET = CW'(prom_ctrl_pkg::SETUP_CYC);
  localparam logic [CW-1:0] PUL = CW'(PULSE_CYC);
  localparam logic [3:0] TRIES = 4'(prom_ctrl_pkg::MAX_TRIES);
  localparam logic [prom_ctrl_pkg::ADDR_W-1:0] A_FIRST = prom_ctrl_pkg::ADDR_W'(FIRST);
  localparam logic [prom_ctrl_pkg::ADDR_W-1:0] A_LAST = prom_ctrl_pkg::ADDR_W'(LAST);

  state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [3:0] tries_reg, tries_next;
  logic [1:0] op_reg, op_next;
  logic [prom_ctrl_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [prom_ctrl_pkg::DATA_W-1:0] rd_reg, rd_next;
  logic done_reg, done_next, fail_reg, fail_next;
  logic [prom_ctrl_pkg::DATA_W-1:0] din_s1_reg, din_s2_reg;

  // Data returning from the memory is asynchronous to the controller, so it is synchronised.
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
    end
    else
    begin
      din_s1_reg <= DATA_LINES_IN;
      din_s2_reg <= din_s1_reg;
    end
  end

  // Next-state logic for all sequences.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
    tries_next = tries_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    fail_next = fail_reg;
    unique case (state_reg)
      IDLE:
      begin
        if (REQ_VALID)
        begin
          op_next = REQ_OP;
          fail_next = 1'b0;
          addr_next = (REQ_OP == 2'(prom_ctrl_pkg::OP_PROG)) ? A_FIRST : REQ_ADDR;
          if (REQ_OP == 2'(prom_ctrl_pkg::OP_ID))
            addr_next = prom_ctrl_pkg::ADDR_W'(REQ_ADDR[prom_ctrl_pkg::ID_SEL_BIT]);
          cnt_next = (REQ_OP == 2'(prom_ctrl_pkg::OP_PROG)) ? SET : ACC;
          state_next = (REQ_OP == 2'(prom_ctrl_pkg::OP_PROG)) ? P1_SET : SETUP;
        end
      end
      SETUP:
      begin
        cnt_next = SET;
        state_next = RD_WAIT;
      end
      RD_WAIT:
        if (cnt_reg == '0)
        begin
          rd_next = din_s2_reg;
          state_next = FINISH;
        end
      P1_SET: // Both enables high, supply on: programming inhibited until the pulse.
        if (cnt_reg == '0)
        begin
          // A counted state lasts its load plus one cycle, so the pulse loads one less.
          cnt_next = PUL - 1'b1;
          state_next = P1_PULSE;
        end
      P1_PULSE:
        if (cnt_reg == '0)
        begin
          cnt_next = SET;
          state_next = P1_HOLD;
        end
      P1_HOLD: // One pulse per location before any verify.
        if (cnt_reg == '0)
        begin
          cnt_next = SET;
          if (addr_reg == A_LAST)
          begin
            addr_next = A_FIRST;
            tries_next = '0;
            state_next = V_SET;
          end
          else
          begin
            addr_next = addr_reg + 1'b1;
            state_next = P1_SET;
          end
        end
      V_SET:
        if (cnt_reg == '0)
        begin
          cnt_next = ACC + SET;
          state_next = V_READ;
        end
      V_READ: // Full byte compare; pulse again or flag after the last try.
        if (cnt_reg == '0)
        begin
          cnt_next = SET;
          if (din_s2_reg == PROG_DATA)
          begin
            tries_next = '0;
            if (addr_reg == A_LAST)
              state_next = FINISH;
            else
            begin
              addr_next = addr_reg + 1'b1;
              state_next = V_SET;
            end
          end
          else if (tries_reg == TRIES)
          begin
            fail_next = 1'b1;
            state_next = FINISH;
          end
          else
          begin
            tries_next = tries_reg + 1'b1;
            cnt_next = PUL - 1'b1;
            state_next = V_PULSE;
          end
        end
      V_PULSE:
        if (cnt_reg == '0)
        begin
          cnt_next = SET;
          state_next = V_HOLD;
        end
      V_HOLD:
        if (cnt_reg == '0)
        begin
          cnt_next = SET;
          state_next = V_SET;
        end
      FINISH:
      begin
        done_next = 1'b1;
        state_next = IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg <= IDLE;
      cnt_reg <= '0;
      tries_reg <= '0;
      op_reg <= '0;
      addr_reg <= '0;
      rd_reg <= prom_ctrl_pkg::ERASED_BYTE;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      tries_reg <= tries_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
    end
  end

  // Pin decode; the memory stays deselected whenever no access is in progress.
  logic prog_phase, pulse_on, rd_on;
  assign prog_phase = (op_reg == 2'(prom_ctrl_pkg::OP_PROG)) && (state_reg != IDLE);
  assign pulse_on = (state_reg == P1_PULSE) || (state_reg == V_PULSE);
  assign rd_on = (state_reg == SETUP) || (state_reg == RD_WAIT);
  assign CHIP_SEL_B = !(rd_on || pulse_on);
  assign OUT_EN_B = !(rd_on || state_reg == V_READ);
  assign PROG_SUPPLY_EN = prog_phase;
  assign ID_HV_EN = rd_on && (op_reg == 2'(prom_ctrl_pkg::OP_ID));
  // Host drives data only while output enable is high in a program phase, never contending.
  assign DATA_LINES_OE = prog_phase && (state_reg != V_READ) && (state_reg != FINISH);
  assign DATA_LINES_OUT = PROG_DATA;
  assign ADDRESS_LINES = addr_reg;
  assign PROG_ADDR = addr_reg;
  assign REQ_READY = (state_reg == IDLE);
  assign RD_DATA = rd_reg;
  assign DONE = done_reg;
  assign FAIL = fail_reg;

  // Checks.
  sequence pulse_seq;
    !CHIP_SEL_B && OUT_EN_B && PROG_SUPPLY_EN;
  endsequence
  no_contend_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    DATA_LINES_OE |-> OUT_EN_B) else $error("Host drives data while memory may.");
  pulse_form_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $fell(CHIP_SEL_B) && PROG_SUPPLY_EN |-> pulse_seq ##0 DATA_LINES_OE)
    else $error("Program pulse without data or with output enabled.");
  first_pass_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (state_reg == V_SET) && ($past(state_reg) == P1_HOLD) |-> ($past(addr_reg) == A_LAST))
    else $error("Verify began before every place had its first pulse.");
  try_limit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    tries_reg <= TRIES) else $error("Too many program pulses on one location.");
  fail_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $rose(fail_reg) |-> (tries_reg == TRIES) ##1 DONE) else $error("Failure flagged wrongly.");
  verify_pins_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (state_reg == V_READ) |-> CHIP_SEL_B && !OUT_EN_B && !DATA_LINES_OE)
    else $error("Verify pin levels wrong.");
  id_pins_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ID_HV_EN |-> !CHIP_SEL_B && !OUT_EN_B && (ADDRESS_LINES[prom_ctrl_pkg::ADDR_W-1:1] == '0))
    else $error("Id mode pins wrong.");
  inhibit_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (state_reg == P1_SET) |-> CHIP_SEL_B && OUT_EN_B && PROG_SUPPLY_EN)
    else $error("Setup does not inhibit.");
endmodule // prom_ctrl

//--- verification/prom_model.sv
// Pin-level model of the byte-wide programmable memory on the far side of the controller.
// Assumes the bench resolves the shared data lines and feeds the resolved level back in.
`timescale 1ns/1ns
module prom_model #(
  parameter int PW = 4,
  parameter int WEAK = 2,
  parameter logic [7:0] MFG_ID = 8'h3C, // Arbitrary value.
  parameter logic [7:0] DEV_ID = 8'hC3 // Arbitrary value.
) (
  // Pins, plus a clock used to time pulses and to delay read data.
  input wire logic clk,
  input wire logic [18:0] addr,
  input wire logic [7:0] d_in,
  input wire logic d_drv,
  input wire logic cs_b,
  input wire logic oe_b,
  input wire logic vpp,
  input wire logic id_hv,
  // Model outputs and observations.
  output logic [7:0] q,
  output logic q_oe,
  output int bad,
  output int maxp
);
  logic [7:0] mem [int]; // Sparse, so all 524288 places fit.
  int n [int];
  int width = 0;
  int bad_c = 0;
  int max_c = 0;
  int k;
  logic vpp_q = 1'b0;
  logic [7:0] d_lat;
  assign bad = bad_c;
  assign maxp = max_c;
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF; // Unwritten places read erased.
  endfunction
  // Drive only in read, verify and id modes; standby and inhibit release.
  assign q_oe = (!cs_b && !oe_b && !vpp) || (cs_b && !oe_b && vpp);
  // Half a cycle of access delay, so a controller that samples too early sees stale data.
  always @(negedge clk)
    q <= id_hv ? (addr[0] ? DEV_ID : MFG_ID) : rd(int'(addr));
  // Time each pulse; a weak place needs a second pulse before its bits take.
  always @(posedge clk)
  begin
    if (vpp && !vpp_q)
    begin
      max_c = 0;
      n.delete();
    end
    vpp_q = vpp;
    if (id_hv && !cs_b && !oe_b && addr[18:1] != '0)
      bad_c++;
    if (vpp && oe_b && !cs_b)
    begin
      width++;
      d_lat = d_in;
      if (!d_drv)
        bad_c++;
    end
    else if (width != 0)
    begin
      k = int'(addr);
      if (width != PW)
        bad_c++;
      n[k] = n.exists(k) ? n[k] + 1 : 1;
      if (n[k] > max_c)
        max_c = n[k];
      if (k != WEAK || n[k] > 1)
        mem[k] = rd(k) & d_lat; // Bits can only fall.
      width = 0;
    end
  end
endmodule // prom_model

//--- verification/eprom_mode_and_program_access_bench.sv
// Self-checking bench for the memory controller against the pin-level memory model.
// Assumes a 10 MHz clock, a shortened pulse and a four-place program range.
`timescale 1ns/1ns
module eprom_mode_and_program_access_bench;
  localparam int PW = 4;
  localparam int LAST = 3;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, done, fail, dl_oe, cs_b, oe_b, vpp, id_hv, m_oe;
  logic [1:0] req_op = '0;
  logic [18:0] req_addr = '0;
  logic [18:0] prog_addr, a_lines;
  logic [7:0] pat = 8'h5A;
  logic [7:0] last = 8'h00;
  logic [7:0] rd_data, dl_out, m_q, bus, prog_data;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int bad, maxp;
  always #50 sys_clk = ~sys_clk;
  assign prog_data = pat ^ prog_addr[7:0];
  // A released bus shows the inverse of its last level, never a friendly value.
  assign bus = dl_oe ? dl_out : (m_oe ? m_q : ~last);
  prom_ctrl #(.PULSE_CYC(PW), .FIRST(0), .LAST(LAST)) dut (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_ADDR(req_addr),
    .PROG_ADDR(prog_addr), .PROG_DATA(prog_data), .DONE(done), .FAIL(fail), .RD_DATA(rd_data),
    .ADDRESS_LINES(a_lines), .DATA_LINES_IN(bus), .DATA_LINES_OUT(dl_out),
    .DATA_LINES_OE(dl_oe), .CHIP_SEL_B(cs_b), .OUT_EN_B(oe_b), .PROG_SUPPLY_EN(vpp),
    .ID_HV_EN(id_hv));
  prom_model #(.PW(PW)) mem (.clk(sys_clk), .addr(a_lines), .d_in(bus), .d_drv(dl_oe),
    .cs_b(cs_b), .oe_b(oe_b), .vpp(vpp), .id_hv(id_hv), .q(m_q), .q_oe(m_oe), .bad(bad),
    .maxp(maxp));
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watch for two drivers and cut a hang short.
  always @(posedge sys_clk)
  begin
    last <= bus;
    cycles <= cycles + 1;
    if (dl_oe === 1'b1 && m_oe === 1'b1)
      check(1'b0, "bus contention");
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end
  // One request, held for one cycle and checked as taken, then a bounded wait for completion.
  task automatic run(input logic [1:0] op, input logic [18:0] a);
    int i;
    @(negedge sys_clk);
    req_op = op;
    req_addr = a;
    req_valid = 1'b1;
    check(req_ready === 1'b1, "controller not ready");
    @(negedge sys_clk);
    check(req_ready === 1'b0, "request not taken");
    req_valid = 1'b0;
    for (i = 0; i < 5000 && done !== 1'b1; i++)
      @(negedge sys_clk);
    check(done === 1'b1, "no completion");
  endtask
  task automatic t_reset();
    repeat (20) @(negedge sys_clk);
    check({cs_b, oe_b, vpp, dl_oe, done} === 5'b11000, "pins wrong in reset");
    check(rd_data === 8'hFF, "read data reset value");
    rst_b = 1'b1;
    $display("reset test done");
  endtask
  task automatic t_read_erased();
    run(prom_ctrl_pkg::OP_READ, 19'h7_FFFF);
    check(rd_data === 8'hFF, "erased top byte");
    $display("erased read test done");
  endtask
  task automatic t_id();
    // Upper request bits set on purpose: the controller must hold those lines low.
    run(prom_ctrl_pkg::OP_ID, 19'h7_FFFE);
    check(rd_data === 8'h3C, "maker byte");
    run(prom_ctrl_pkg::OP_ID, 19'h0_0001);
    check(rd_data === 8'hC3, "device byte");
    check(bad === 0, "id address lines");
    $display("id test done");
  endtask
  // Program the range with one weak place, then read every place back in normal mode.
  task automatic t_prog();
    int a;
    pat = 8'h5A;
    run(prom_ctrl_pkg::OP_PROG, 19'h0_0000);
    check(fail === 1'b0, "program failed");
    check(maxp === 2, "weak place not repulsed once");
    check(bad === 0, "pulse width or data drive");
    for (a = 0; a <= LAST; a++)
    begin
      run(prom_ctrl_pkg::OP_READ, 19'(a));
      check(rd_data === (8'h5A ^ 8'(a)), "read back");
    end
    $display("program test done");
  endtask
  // Asking for ones over programmed zeros must exhaust the tries and fail.
  task automatic t_no_rise();
    pat = 8'hA5;
    run(prom_ctrl_pkg::OP_PROG, 19'h0_0000);
    check(fail === 1'b1, "failure not flagged");
    check(maxp === 11, "pulse count per place");
    run(prom_ctrl_pkg::OP_READ, 19'h0_0001);
    check(rd_data === 8'h00, "zeros came back high");
    check(fail === 1'b0, "failure not cleared");
    check(bad === 0, "pulse width or data drive");
    $display("no rise test done");
  endtask
  initial
  begin
    t_reset();
    t_read_erased();
    t_id();
    t_prog();
    t_no_rise();
    close_out();
  end
endmodule // eprom_mode_and_program_access_bench
